/* File: verilog/sct_ctrl.sv */
// controller end: init, refresh, power-down and burst sequencing
`timescale 1ns/100ps
module sct_ctrl #(
  parameter int DW      = 16,
  parameter int FIFO_D  = 32,
  parameter int CL      = sct_pkg::CL_DEF,   // RL14
  parameter int BL      = sct_pkg::BL_DEF,
  parameter int WAG_CYC = sct_pkg::WAG_CYC,  // 5 on the middle grade
  parameter int PWR_CYC = sct_pkg::PWRUP_CYC
) (
  // clock and reset
  input  wire logic          core_clk_i,
  input  wire logic          sys_rst_i,
  // request
  input  wire logic          req_valid_i,
  input  wire logic          req_write_i,
  input  wire logic [1:0]    req_bank_i,
  input  wire logic [11:0]   req_row_i,
  input  wire logic [7:0]    req_col_i,
  output logic               req_ready_o,
  // write data
  input  wire logic          wr_valid_i,
  input  wire logic [DW-1:0] wr_data_i,
  output logic               wr_ready_o,
  // read data
  output logic               rd_valid_o,
  output logic [DW-1:0]      rd_data_o,
  // power and status
  input  wire logic          sleep_i,
  output logic               init_done_o,
  // pins
  sct_if.ctrl                bus
);
  typedef enum logic [10:0] {
    S_WAIT = 11'h001, S_PREA = 11'h002, S_REF = 11'h004, S_LMR = 11'h008,
    S_IDLE = 11'h010, S_PDN  = 11'h020, S_RD  = 11'h040, S_PRE = 11'h080,
    S_WR   = 11'h100, S_WB   = 11'h200, S_NONE = 11'h400
  } sct_ctrl_state_t;
  typedef struct packed {
    sct_ctrl_state_t st;    // current state
    sct_ctrl_state_t after; // state after a wait
    logic [11:0]     wcnt;  // wait cycles left
    logic [9:0]      rcnt;  // refresh interval
    logic            pend;  // refresh owed
    logic [1:0]      nref;  // refreshes left in a group
    logic            init;  // init finished
    logic            wr;    // access is a write
    logic [7:0]      col;   // access column
    logic [3:0]      beat;  // write words left
    logic [3:0]      cmd;   // command pins
    logic            cke;   // clock enable pin
    logic [1:0]      ba;    // bank pins
    logic [11:0]     addr;  // address pins
    logic            dqm;   // mask pin
    logic [DW-1:0]   dq;    // data pins
    logic            dq_oe; // data drive
    logic            rdy;   // request ready
    logic            rdv;   // read word valid
    logic [DW-1:0]   rdd;   // read word
  } sct_ctrl_st_t;
  localparam logic [11:0] AP       = 12'(1 << sct_pkg::AP_BIT);
  localparam logic [11:0] MODE_WRD = 12'(CL << sct_pkg::MR_CL_LSB) | 12'(sct_pkg::MR_BL_CODE);
  sct_ctrl_st_t s_ff, nxt_s;
  logic                  pop;
  logic [DW-1:0]         fdata;
  logic [$clog2(FIFO_D):0] fcnt;
  logic                  take;
  logic                  hit;

  // gap of c edges from this command to the one issued in state a
  function automatic sct_ctrl_st_t go(sct_ctrl_st_t x, int c, sct_ctrl_state_t a);
    sct_ctrl_st_t y;
    y = x;
    if (c <= 1) begin
      y.st = a;
    end else begin
      y.st    = S_WAIT;
      y.wcnt  = 12'(c - 1);
      y.after = a;
    end
    return y;
  endfunction

  // write data buffer; its ready is the user's back-pressure
  sct_fifo #(.W(DW), .D(FIFO_D)) u_sct_fifo (
    .core_clk_i  (core_clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (wr_valid_i),
    .in_data_i   (wr_data_i),
    .in_ready_o  (wr_ready_o),
    .out_valid_o (),
    .out_data_o  (fdata),
    .out_ready_i (pop),
    .count_o     (fcnt)
  );

  // pins straight from the state register
  assign {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} = s_ff.cmd;
  assign bus.cke     = s_ff.cke;
  assign bus.ba      = s_ff.ba;
  assign bus.addr    = s_ff.addr;
  assign bus.dqm     = s_ff.dqm;
  assign bus.dq_c    = s_ff.dq;
  assign bus.dq_c_oe = s_ff.dq_oe;
  assign req_ready_o = s_ff.rdy;
  assign rd_valid_o  = s_ff.rdv;
  assign rd_data_o   = s_ff.rdd;
  assign init_done_o = s_ff.init;

  // a write is only taken once a whole burst sits in the buffer
  assign take = s_ff.rdy & req_valid_i & (~req_write_i | (32'(fcnt) >= BL));
  assign hit  = s_ff.rcnt == '0;

  // sequencer; each state's command lands in the register at that state's edge
  always_comb begin
    nxt_s       = s_ff;
    pop         = 1'b0;
    nxt_s.cmd   = sct_pkg::CMD_NOP;
    nxt_s.dq_oe = 1'b0;
    nxt_s.rdv   = bus.dq_m_oe;
    nxt_s.rdd   = bus.dq_m;
    nxt_s.rcnt  = hit ? 10'(sct_pkg::REF_CYC) : s_ff.rcnt - 10'h1;
    nxt_s.pend  = s_ff.pend | hit;
    case (s_ff.st)
      S_WAIT: begin
        if (s_ff.wcnt <= 12'h1) begin
          nxt_s.st = s_ff.after;
        end else begin
          nxt_s.wcnt = s_ff.wcnt - 12'h1;
        end
      end
      S_PREA: begin
        // power-up pause done: close all banks first
        nxt_s.cmd  = sct_pkg::CMD_PRE;
        nxt_s.addr = AP;
        nxt_s      = go(nxt_s, sct_pkg::RP_CYC, S_REF);
      end
      S_REF: begin
        nxt_s.cmd  = sct_pkg::CMD_REF; // RL19
        nxt_s.nref = s_ff.nref - 2'h1;
        if (s_ff.nref > 2'h1) begin
          nxt_s = go(nxt_s, sct_pkg::RFC_CYC, S_REF); // RL13
        end else begin
          nxt_s = go(nxt_s, sct_pkg::RFC_CYC, s_ff.init ? S_IDLE : S_LMR);
        end
      end
      S_LMR: begin
        // reached only with every bank closed
        nxt_s.cmd  = sct_pkg::CMD_LMR; // RL18
        nxt_s.addr = MODE_WRD;
        nxt_s.init = 1'b1;
        nxt_s      = go(nxt_s, sct_pkg::MLS_CYC, S_IDLE); // RL11
      end
      S_IDLE: begin
        if (take) begin
          nxt_s.cmd  = sct_pkg::CMD_ACT;
          nxt_s.ba   = req_bank_i;
          nxt_s.addr = req_row_i;
          nxt_s.wr   = req_write_i;
          nxt_s.col  = req_col_i;
          nxt_s      = go(nxt_s, sct_pkg::RCD_CYC, req_write_i ? S_WR : S_RD);
        end else if (s_ff.pend) begin
          nxt_s.pend = hit; // set wins over clear
          nxt_s.nref = 2'h1;
          nxt_s.st   = S_REF;
        end else if (sleep_i && !req_valid_i) begin
          nxt_s.cke = 1'b0; // RL4 RL15
          nxt_s.st  = S_PDN;
        end
      end
      S_PDN: begin
        // refresh owed also wakes the part
        if (!sleep_i || s_ff.pend) begin
          nxt_s.cke = 1'b1;
          nxt_s     = go(nxt_s, sct_pkg::CXD_CYC, S_IDLE); // RL5
        end
      end
      S_RD: begin
        nxt_s.cmd  = sct_pkg::CMD_RD;
        nxt_s.addr = {4'h0, s_ff.col};
        nxt_s      = go(nxt_s, BL, S_PRE);
      end
      S_PRE: begin
        nxt_s.cmd  = sct_pkg::CMD_PRE;
        nxt_s.addr = 12'h000;
        nxt_s      = go(nxt_s, sct_pkg::RP_CYC, S_IDLE);
      end
      S_WR: begin
        // first word with the command, auto precharge on
        nxt_s.cmd   = sct_pkg::CMD_WR; // RL10
        nxt_s.addr  = {4'h0, s_ff.col} | AP;
        nxt_s.dq    = fdata;
        nxt_s.dq_oe = 1'b1;
        pop         = 1'b1;
        nxt_s.beat  = 4'(BL - 1);
        nxt_s       = go(nxt_s, 1, (BL > 1) ? S_WB : S_NONE);
        if (BL <= 1) begin
          nxt_s = go(nxt_s, WAG_CYC, S_IDLE); // RL6
        end
      end
      S_WB: begin
        nxt_s.dq    = fdata;
        nxt_s.dq_oe = 1'b1;
        pop         = 1'b1;
        nxt_s.beat  = s_ff.beat - 4'h1;
        if (s_ff.beat <= 4'h1) begin
          // recovery plus precharge before the next activate
          nxt_s = go(nxt_s, WAG_CYC, S_IDLE); // RL1 RL3 RL6 RL7 RL17 RL20
        end
      end
      default: begin
        nxt_s.st = S_IDLE;
      end
    endcase
    nxt_s.rdy = (nxt_s.st == S_IDLE) & ~nxt_s.pend;
  end

  // state register; starts in the power-up pause with enable high
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_ff <= '{st: S_WAIT, after: S_PREA, wcnt: 12'(PWR_CYC), // RL13
                rcnt: 10'(sct_pkg::REF_CYC), pend: 1'b0, nref: 2'h2, init: 1'b0,
                wr: 1'b0, col: '0, beat: '0, cmd: sct_pkg::CMD_NOP, cke: 1'b1,
                ba: '0, addr: '0, dqm: 1'b0, dq: '0, dq_oe: 1'b0, rdy: 1'b0,
                rdv: 1'b0, rdd: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end
endmodule

/* File: common/sct_pkg.sv */
// shared constants for the sdram command timing controller and memory ends
// Function
// RL1 - one clock from last write word to stop
// RL2 - column commands accepted one clock apart
// RL3 - new column command one clock after data
// RL4 - clock enable low suspends one clock later
// RL5 - clock enable high resumes one clock later
// RL6 - auto precharge write waits before activate
// RL7 - two clocks last write word to precharge
// RL8 - write mask blocks same-cycle data word
// RL9 - read mask floats outputs two clocks later
// RL10 - first write word sampled with command
// RL11 - two clocks after mode load before activate
// RL12 - precharge floats read data after latency
// RL13 - power-up pause then two refreshes
// RL14 - fastest grade never uses latency two
// RL15 - clock stays constant during accesses
// RL16 - clock toggles during self refresh exit
// RL17 - internal precharge after write recovery
// RL18 - mode load only idle, then settle
// RL19 - refresh with enable low self-refreshes
// RL20 - controller gaps are per-grade parameters; only WAG_CYC is one, the other gaps are fixed sct_pkg constants
package sct_pkg;
  // clock and raw times
  localparam int CLK_NS     = 25;
  localparam int PWRUP_NS   = 100000;
  localparam int REF_ROW_NS = 15625;   // 64 ms over 4096 rows
  localparam int RP_NS      = 20;
  localparam int RCD_NS     = 20;
  localparam int RFC_NS     = 66;
  // cycle counts: least times round up, interval rounds down
  localparam int PWRUP_CYC = (PWRUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int REF_CYC   = REF_ROW_NS / CLK_NS;
  localparam int RP_CYC    = (RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RCD_CYC   = (RCD_NS + CLK_NS - 1) / CLK_NS;
  localparam int RFC_CYC   = (RFC_NS + CLK_NS - 1) / CLK_NS;
  // clock-defined gaps
  localparam int WSG_CYC = 1;
  localparam int CCS_CYC = 1;
  localparam int WCG_CYC = 1;
  localparam int WAG_CYC = 5;
  localparam int WPG_CYC = 2;
  localparam int MRF_CYC = 2;
  localparam int MLS_CYC = 2;
  localparam int CXD_CYC = 1;
  // defaults for read latency and burst length
  localparam int CL_DEF = 2;
  localparam int BL_DEF = 4;
  // command codes {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_LMR = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR  = 4'h4;
  localparam logic [3:0] CMD_RD  = 4'h5;
  localparam logic [3:0] CMD_BST = 4'h6;
  localparam logic [3:0] CMD_NOP = 4'h7;
  // mode word and address fields
  localparam int         MR_CL_LSB  = 4;
  localparam logic [2:0] MR_BL_CODE = 3'h2;
  localparam int         AP_BIT     = 10;
  localparam logic [11:0] MODE_RST  = 12'h022;
endpackage

/* File: common/sct_if.sv */
// command, address, mask and split data pins between controller and memory
`timescale 1ns/100ps
interface sct_if #(parameter int DW = 16);
  logic          cke;      // clock enable
  logic          cs_n;     // chip select
  logic          ras_n;    // row strobe
  logic          cas_n;    // column strobe
  logic          we_n;     // write enable
  logic [1:0]    ba;       // bank
  logic [11:0]   addr;     // row, column or op code
  logic          dqm;      // data mask
  logic [DW-1:0] dq_c;     // data from controller
  logic          dq_c_oe;  // controller drives data
  logic [DW-1:0] dq_m;     // data from memory
  logic          dq_m_oe;  // memory drives data
  modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq_c, dq_c_oe,
                input dq_m, dq_m_oe);
  modport mem  (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq_c, dq_c_oe,
                output dq_m, dq_m_oe);
endinterface

/* File: verilog/sct_fifo.sv */
// write data fifo with valid/ready on both sides
`timescale 1ns/100ps
module sct_fifo #(
  parameter int W = 16,
  parameter int D = 32
) (
  // clock and reset
  input  wire logic          core_clk_i,
  input  wire logic          sys_rst_i,
  // filling side
  input  wire logic          in_valid_i,
  input  wire logic [W-1:0]  in_data_i,
  output logic               in_ready_o,
  // draining side
  output logic               out_valid_o,
  output logic [W-1:0]       out_data_o,
  input  wire logic          out_ready_i,
  output logic [$clog2(D):0] count_o
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;  // storage
    logic [AW-1:0]       wp;   // write index
    logic [AW-1:0]       rp;   // read index
    logic [AW:0]         cnt;  // words held
    logic                rdy;  // room left
  } sct_fifo_st_t;
  sct_fifo_st_t s_ff, nxt_s;
  logic push, pop;

  // handshakes on both sides
  assign push        = in_valid_i & s_ff.rdy;
  assign pop         = out_ready_i & (s_ff.cnt != '0);
  assign in_ready_o  = s_ff.rdy;
  assign out_valid_o = s_ff.cnt != '0;
  assign out_data_o  = s_ff.mem[s_ff.rp];
  assign count_o     = s_ff.cnt;

  // pointer and count update; ready registered so it needs no logic at the port
  always_comb begin
    nxt_s = s_ff;
    if (push) begin
      nxt_s.mem[s_ff.wp] = in_data_i;
      nxt_s.wp = AW'((32'(s_ff.wp) + 1) % D);
    end
    if (pop) begin
      nxt_s.rp = AW'((32'(s_ff.rp) + 1) % D);
    end
    nxt_s.cnt = (AW + 1)'(32'(s_ff.cnt) + 32'(push) - 32'(pop));
    nxt_s.rdy = 32'(nxt_s.cnt) != D;
  end

  // state register
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_ff <= '{mem: '0, wp: '0, rp: '0, cnt: '0, rdy: 1'b1};
    end else begin
      s_ff <= nxt_s;
    end
  end
endmodule

/* File: verilog/sct_mem.sv */
// memory end: command decode, bursts, masks, clock enable and latency pipe
`timescale 1ns/100ps
module sct_mem #(
  parameter int DW   = 16,
  parameter int COLS = 16
) (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  // pins
  sct_if.mem        bus,
  // user side status
  output logic      self_ref_o,
  output logic      suspended_o
);
  localparam int CB = $clog2(COLS);
  typedef struct packed {
    logic [4*COLS-1:0][DW-1:0] arr;   // four banks of columns
    logic                      susp;  // enable seen low last edge
    logic                      sref;  // in self refresh
    logic [11:0]               mode;  // mode word
    logic                      burst; // burst running
    logic                      wr;    // burst is a write
    logic [1:0]                ba;    // burst bank
    logic [CB-1:0]             col;   // burst column
    logic [3:0]                left;  // words left
    logic [1:0][DW-1:0]        pd;    // read latency pipe data
    logic [1:0]                pv;    // read latency pipe valid
    logic [1:0]                dqm_d; // mask pipe
    logic [DW-1:0]             q;     // output word
    logic                      oe;    // output drive
  } sct_mem_st_t;
  sct_mem_st_t s_ff, nxt_s;
  logic [3:0]    cmd;
  logic          en;
  logic [1:0]    cl;
  logic [3:0]    blen;
  logic [DW-1:0] fetch;
  logic          fv;
  logic [CB+1:0] cidx;

  assign bus.dq_m    = s_ff.q;
  assign bus.dq_m_oe = s_ff.oe;
  assign self_ref_o  = s_ff.sref;
  assign suspended_o = s_ff.susp;

  // decode helpers; a deselected chip sees no operation
  assign cmd   = bus.cs_n ? sct_pkg::CMD_NOP : {1'b0, bus.ras_n, bus.cas_n, bus.we_n};
  assign en    = ~s_ff.susp & ~s_ff.sref;
  assign cl    = s_ff.mode[sct_pkg::MR_CL_LSB +: 2];
  assign blen  = 4'h1 << s_ff.mode[1:0];
  assign fetch = s_ff.arr[{s_ff.ba, s_ff.col}];
  assign fv    = s_ff.burst & ~s_ff.wr;
  assign cidx  = {bus.ba, bus.addr[CB-1:0]};

  // everything except the enable sample and the self refresh exit freezes while suspended
  always_comb begin
    nxt_s = s_ff;
    nxt_s.susp = ~bus.cke;
    if (s_ff.sref && bus.cke) begin
      nxt_s.sref = 1'b0; // leave self refresh; enable seen next edge
    end
    if (en) begin // RL4 RL5
      // latency pipe: stage 0 is this edge's fetch
      nxt_s.pv = {s_ff.pv[0], fv};
      nxt_s.pd = {s_ff.pd[0], fetch};
      case (cl)
        2'h1: begin
          nxt_s.q  = fetch;
          nxt_s.oe = fv & ~s_ff.dqm_d[1]; // RL9
        end
        2'h2: begin
          nxt_s.q  = s_ff.pd[0];
          nxt_s.oe = s_ff.pv[0] & ~s_ff.dqm_d[1]; // RL9
        end
        default: begin
          nxt_s.q  = s_ff.pd[1];
          nxt_s.oe = s_ff.pv[1] & ~s_ff.dqm_d[1]; // RL9
        end
      endcase
      nxt_s.dqm_d = {s_ff.dqm_d[0], bus.dqm};
      // burst stepping, unless a new command takes the bus this edge
      if (s_ff.burst) begin
        if (s_ff.wr && !bus.dqm) begin
          nxt_s.arr[{s_ff.ba, s_ff.col}] = bus.dq_c; // RL8
        end
        nxt_s.col  = CB'(s_ff.col + 1'b1);
        nxt_s.left = s_ff.left - 4'h1;
        nxt_s.burst = s_ff.left > 4'h1;
      end
      case (cmd)
        sct_pkg::CMD_RD: begin // RL2
          nxt_s.burst = 1'b1;
          nxt_s.wr    = 1'b0;
          nxt_s.ba    = bus.ba;
          nxt_s.col   = bus.addr[CB-1:0];
          nxt_s.left  = blen;
        end
        sct_pkg::CMD_WR: begin // RL2
          // first word rides with the command
          if (!bus.dqm) begin
            nxt_s.arr[cidx] = bus.dq_c; // RL10 RL8
          end
          nxt_s.burst = blen > 4'h1;
          nxt_s.wr    = 1'b1;
          nxt_s.ba    = bus.ba;
          nxt_s.col   = CB'(bus.addr[CB-1:0] + 1'b1);
          nxt_s.left  = blen - 4'h1;
        end
        sct_pkg::CMD_BST, sct_pkg::CMD_PRE: begin
          // words already in the pipe still leave, so outputs float latency later
          nxt_s.burst = 1'b0; // RL12
        end
        sct_pkg::CMD_LMR: begin
          nxt_s.mode = bus.addr;
        end
        sct_pkg::CMD_REF: begin
          // auto refresh needs no state here; enable low means self refresh
          nxt_s.sref = ~bus.cke; // RL19
        end
        default: begin
          nxt_s.sref = s_ff.sref; // nop, activate
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_ff <= '{arr: '0, susp: 1'b1, sref: 1'b0, mode: sct_pkg::MODE_RST, burst: 1'b0,
                wr: 1'b0, ba: '0, col: '0, left: '0, pd: '0, pv: '0, dqm_d: '0,
                q: '0, oe: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end
endmodule

/* File: sim/sct_link_checker.sv */
// concurrent checks on the pins between the controller and memory ends
`timescale 1ns/100ps
module sct_link_checker #(
  parameter int DW = 16
) (
  // clock and reset
  input  wire logic          core_clk_i,
  input  wire logic          sys_rst_i,
  // command pins
  input  wire logic          cke,
  input  wire logic          cs_n,
  input  wire logic          ras_n,
  input  wire logic          cas_n,
  input  wire logic          we_n,
  input  wire logic [1:0]    ba,
  input  wire logic [11:0]   addr,
  input  wire logic          dqm,
  // split data pins
  input  wire logic [DW-1:0] dq_c,
  input  wire logic          dq_c_oe,
  input  wire logic [DW-1:0] dq_m,
  input  wire logic          dq_m_oe
);
  logic [3:0] cmd;    // packed command code
  logic       nop_c;  // inhibit or no-operation
  logic       wr_c;   // write column command
  logic       rd_c;   // read column command
  logic       act_c;  // activate
  logic       pre_c;  // precharge
  logic       lmr_c;  // mode load
  logic       ref_c;  // refresh
  logic       bst_c;  // burst stop
  // decode once so the properties stay short
  assign cmd   = {cs_n, ras_n, cas_n, we_n};
  assign nop_c = cs_n | (cmd == sct_pkg::CMD_NOP);
  assign wr_c  = (cmd == sct_pkg::CMD_WR);
  assign rd_c  = (cmd == sct_pkg::CMD_RD);
  assign act_c = (cmd == sct_pkg::CMD_ACT);
  assign pre_c = (cmd == sct_pkg::CMD_PRE);
  assign lmr_c = (cmd == sct_pkg::CMD_LMR);
  assign ref_c = (cmd == sct_pkg::CMD_REF);
  assign bst_c = (cmd == sct_pkg::CMD_BST);
  // one clock domain, one reset
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  // mode word needs a settle clock before activate or refresh
  chk_mode_settle: assert property (lmr_c |=> !(act_c || ref_c))
    else $error("activate or refresh too soon after mode load");
  // first write word rides with the command
  chk_wdata_with: assert property (wr_c |-> dq_c_oe)
    else $error("write command without data");
  // a burst of four words, then the bus is let go
  chk_wburst_len: assert property (wr_c |-> dq_c_oe [*4] ##1 !dq_c_oe)
    else $error("write burst length wrong");
  // write recovery before any precharge
  chk_write_recover: assert property (wr_c |=> !pre_c [*4])
    else $error("precharge inside write recovery");
  // auto precharge plus recovery before the next activate
  chk_write_act_gap: assert property (wr_c |=> !act_c [*7])
    else $error("activate too soon after auto precharge write");
  // no stop or column command on or before the last word
  chk_last_word_gap: assert property (wr_c |=> !(bst_c || rd_c || wr_c) [*3])
    else $error("command too close to last write word");
  // a precharge releases the read outputs within the latency
  chk_pre_float: assert property ((pre_c && $past(cke)) |-> ##[1:3] !dq_m_oe)
    else $error("outputs not released after precharge");
  // every accepted read issued with the mask low is answered
  chk_read_answer: assert property ((rd_c && $past(cke) && !dqm) |-> ##[1:3] dq_m_oe)
    else $error("read not answered");
  // both ends never drive the data lines together
  chk_no_contend: assert property (!(dq_c_oe && dq_m_oe))
    else $error("data bus driven from both ends");
  // while suspended the controller sends nothing
  chk_suspend_quiet: assert property ((!$past(cke) && !cke) |-> nop_c)
    else $error("command issued while clock enable low");
endmodule

/* File: sim/tb.sv */
// bench: controller and memory joined, plus a memory end driven by hand
`timescale 1ns/100ps
module tb;
  logic        core_clk_i = 1'b0;  // bench clock
  logic        sys_rst_i  = 1'b1;  // async reset
  logic        req_valid_i, req_write_i, wr_valid_i, sleep_i;
  logic [1:0]  req_bank_i;
  logic [11:0] req_row_i;
  logic [7:0]  req_col_i;
  logic [15:0] wr_data_i, rd_data_o;
  logic        req_ready_o, wr_ready_o, rd_valid_o, init_done_o;
  logic        self_ref_o, suspended_o, self_ref_b, susp_b;
  int          bad_count, tests_run, cyc, i, n, w;
  logic [15:0] rq[$];              // read words seen at the user side
  sct_if #(.DW(16)) u_if ();       // joined pair
  sct_if #(.DW(16)) u_if_b ();     // bench plays the controller here
  sct_ctrl #(.PWR_CYC(20)) u_sct_ctrl (.core_clk_i, .sys_rst_i, .req_valid_i, .req_write_i,
    .req_bank_i, .req_row_i, .req_col_i, .req_ready_o, .wr_valid_i, .wr_data_i,
    .wr_ready_o, .rd_valid_o, .rd_data_o, .sleep_i, .init_done_o, .bus(u_if.ctrl));
  sct_mem u_sct_mem (.core_clk_i, .sys_rst_i, .bus(u_if.mem), .self_ref_o, .suspended_o);
  sct_mem u_sct_mem_b (.core_clk_i, .sys_rst_i, .bus(u_if_b.mem), .self_ref_o(self_ref_b),
    .suspended_o(susp_b));
  sct_link_checker u_chk (.core_clk_i, .sys_rst_i, .cke(u_if.cke), .cs_n(u_if.cs_n),
    .ras_n(u_if.ras_n), .cas_n(u_if.cas_n), .we_n(u_if.we_n), .ba(u_if.ba), .addr(u_if.addr),
    .dqm(u_if.dqm), .dq_c(u_if.dq_c), .dq_c_oe(u_if.dq_c_oe), .dq_m(u_if.dq_m),
    .dq_m_oe(u_if.dq_m_oe));
  // 40 MHz clock
  always #12.5 core_clk_i = ~core_clk_i;
  // collect read words; ceiling far above the run
  always @(posedge core_clk_i) begin
    if (rd_valid_o === 1'b1) rq.push_back(rd_data_o);
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      print_verdict();
    end
  end
  // compare and count
  task check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("checks=%0d errors=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one clock on the hand-driven pins; released data lines show the inverse
  task b_cyc(input logic [3:0] c, input logic m, input logic oe, input logic [15:0] d);
    {u_if_b.cs_n, u_if_b.ras_n, u_if_b.cas_n, u_if_b.we_n} = c;
    u_if_b.dqm = m;
    u_if_b.dq_c_oe = oe;
    u_if_b.dq_c = oe ? d : ~u_if_b.dq_c;
    @(posedge core_clk_i);
    #1;
  endtask
  // write burst at column 0, per-word mask
  task b_wr(input logic [15:0] base, input logic [3:0] msk);
    b_cyc(sct_pkg::CMD_WR, msk[0], 1'b1, base);
    for (int k = 1; k < 4; k++) b_cyc(sct_pkg::CMD_NOP, msk[k], 1'b1, base + 16'(k));
    b_cyc(sct_pkg::CMD_NOP, 1'b0, 1'b0, 16'h0000);
  endtask
  // read at column 0; second clock carries c2 and mask m; fl marks released words
  task b_rd(input logic [3:0] c2, input logic m, input logic [3:0] fl,
            input logic [3:0][15:0] ex);
    b_cyc(sct_pkg::CMD_RD, 1'b0, 1'b0, 16'h0000);
    b_cyc(c2, m, 1'b0, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      b_cyc(sct_pkg::CMD_NOP, 1'b0, 1'b0, 16'h0000);
      if (fl[k]) check({31'h0, u_if_b.dq_m_oe}, 32'h0);
      else check({15'h0, u_if_b.dq_m_oe, u_if_b.dq_m}, {15'h0, 1'b1, ex[k]});
    end
  endtask
  // user request, held until taken
  task req(input logic wr, input int idx);
    int t;
    req_valid_i = 1'b1;
    req_write_i = wr;
    req_bank_i = 2'(idx / 4);
    req_row_i = 12'h001;
    req_col_i = 8'((idx % 4) * 4);
    t = 0;
    do begin
      @(posedge core_clk_i);
      t++;
    end while (req_ready_o !== 1'b1 && t < 3000);
    #1;
    check(32'(t < 3000), 32'h1);
  endtask
  // read one burst back through the joined pair
  task rd_burst(input int idx);
    int t;
    req(1'b0, idx);
    req_valid_i = 1'b0;
    t = 0;
    while (rq.size() < 4 && t < 100) begin
      @(posedge core_clk_i);
      t++;
    end
    #1;
    for (int k = 0; k < 4; k++) check(32'(rq.pop_front()), 32'hC000 + 32'(idx * 4 + k));
  endtask
  // fifo push; valid is set on each call and stays up between back-to-back pushes
  task push(input logic [15:0] d);
    wr_valid_i = 1'b1;
    wr_data_i = d;
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk_i);
      if (wr_ready_o === 1'b1) begin
        n++;
        break;
      end
    end
    #1;
  endtask
  // main sequence
  initial begin
    {req_valid_i, req_write_i, wr_valid_i, sleep_i} = 4'h0;
    {req_bank_i, req_row_i, req_col_i, wr_data_i} = '0;
    {bad_count, tests_run, n} = '0;
    u_if_b.cke = 1'b1;
    u_if_b.ba = 2'h0;
    u_if_b.addr = 12'h000;
    b_cyc(sct_pkg::CMD_NOP, 1'b0, 1'b0, 16'h0000);
    repeat (20) @(posedge core_clk_i);
    #1 sys_rst_i = 1'b0;
    // hand-driven memory: mode, open row, masked writes, reads
    b_cyc(sct_pkg::CMD_NOP, 1'b0, 1'b0, 16'h0000);
    u_if_b.addr = sct_pkg::MODE_RST;
    b_cyc(sct_pkg::CMD_LMR, 1'b0, 1'b0, 16'h0000);
    u_if_b.addr = 12'h000;
    repeat (2) b_cyc(sct_pkg::CMD_NOP, 1'b0, 1'b0, 16'h0000);
    b_cyc(sct_pkg::CMD_ACT, 1'b0, 1'b0, 16'h0000);
    b_cyc(sct_pkg::CMD_NOP, 1'b0, 1'b0, 16'h0000);
    b_wr(16'hA000, 4'h0);
    b_wr(16'hB000, 4'h2);
    b_rd(sct_pkg::CMD_NOP, 1'b0, 4'h0, {16'hB003, 16'hB002, 16'hA001, 16'hB000});
    b_rd(sct_pkg::CMD_NOP, 1'b1, 4'h2, {16'hB003, 16'hB002, 16'hA001, 16'hB000});
    b_rd(sct_pkg::CMD_RD, 1'b0, 4'h0, {16'hB002, 16'hA001, 16'hB000, 16'hB000});
    b_rd(sct_pkg::CMD_PRE, 1'b0, 4'hE, {16'hB003, 16'hB002, 16'hA001, 16'hB000});
    // clock enable and self refresh on the hand-driven end
    u_if_b.cke = 1'b0;
    b_cyc(sct_pkg::CMD_NOP, 1'b0, 1'b0, 16'h0000);
    check({31'h0, susp_b}, 32'h1);
    u_if_b.cke = 1'b1;
    b_cyc(sct_pkg::CMD_NOP, 1'b0, 1'b0, 16'h0000);
    check({31'h0, susp_b}, 32'h0);
    u_if_b.cke = 1'b0;
    b_cyc(sct_pkg::CMD_REF, 1'b0, 1'b0, 16'h0000);
    check({31'h0, self_ref_b}, 32'h1);
    u_if_b.cke = 1'b1;
    repeat (2) b_cyc(sct_pkg::CMD_NOP, 1'b0, 1'b0, 16'h0000);
    check({31'h0, self_ref_b}, 32'h0);
    // joined pair: wake-up, then fill the write fifo until it refuses
    w = 0;
    while (init_done_o !== 1'b1 && w < 300) begin
      @(posedge core_clk_i);
      w++;
    end
    #1;
    check({31'h0, init_done_o}, 32'h1);
    for (i = 0; i < 33; i++) push(16'hC000 + 16'(i));
    wr_valid_i = 1'b0;
    check(32'(n), 32'd32);
    // drain by eight write bursts, then read each back
    for (i = 0; i < 8; i++) req(1'b1, i);
    req_valid_i = 1'b0;
    for (i = 0; i < 8; i++) rd_burst(i);
    // power down and wake, then one more read
    sleep_i = 1'b1;
    w = 0;
    while (suspended_o !== 1'b1 && w < 100) begin
      @(posedge core_clk_i);
      w++;
    end
    #1;
    check({31'h0, suspended_o}, 32'h1);
    sleep_i = 1'b0;
    repeat (4) @(posedge core_clk_i);
    #1;
    check({30'h0, self_ref_o, suspended_o}, 32'h0);
    rd_burst(5);
    print_verdict();
  end
endmodule
